// ==== rtl/acrd_pkg.sv ====
// Purpose: Constants for the codec control byte decoder
// Assumes: Control link sampled by the core clock
// Notes:   Field positions refer to one received byte
`default_nettype none
package acrd_pkg;
  // Address byte
  localparam int          ADDR_TYPE_LSB  = 0;
  localparam logic [1:0]  TYPE_DATA      = 2'h0;
  localparam logic [1:0]  TYPE_STATUS    = 2'h2;
  localparam int          BYTE_BITS      = 8;
  // Status byte fields
  localparam int          ST_CLK_LSB     = 4;
  localparam int          ST_FMT_LSB     = 1;
  localparam int          ST_DC_BIT      = 0;
  // Data byte selectors
  localparam logic [1:0]  SEL_VOLUME     = 2'h0;
  localparam logic [1:0]  SEL_TONE       = 2'h1;
  localparam logic [1:0]  SEL_DEMPH      = 2'h2;
  localparam logic [1:0]  SEL_POWER      = 2'h3;
  localparam int          LOW_BOOST_LSB  = 2;
  localparam int          DEEMPH_LSB     = 3;
  localparam int          MUTE_BIT       = 2;
  // Reset values, no documented ones
  localparam logic [5:0]  FMT_CLK_RST    = 6'h00;
  localparam logic [5:0]  VOLUME_RST     = 6'h00;
  localparam logic [5:0]  TONE_RST       = 6'h00;
  localparam logic [4:0]  DEMPH_RST      = 5'h00;
  localparam logic [1:0]  POWER_RST      = 2'h0;
  localparam logic        LINK_IDLE      = 1'b1;
  // Decoding limits
  localparam logic [5:0]  VOL_MUTE_CODE  = 6'h3e;
  localparam logic [4:0]  BASS_MIN_CAP   = 5'h12;
  localparam logic [4:0]  BASS_MAX_CAP   = 5'h18;
  // Device address, value arbitrary
  localparam logic [5:0]  DEV_ADDR_DEF   = 6'h2a;
endpackage : acrd_pkg
`default_nettype wire

// ==== rtl/acrd_top.sv ====
// Purpose: Decode control link bytes into codec settings
// Assumes: Link pins are asynchronous, two-flop synchronised
// Notes:   Write-only registers; settings leave as decoded outputs
//
// How it works
// (R01) Status byte bit7=0 loads ratio, format
// (R02) Status bit 0 loads DC cancel enable
// (R03) Data bits 7:6 pick target register
// (R04) Clock ratio 512, 384, 256 fs
// (R05) Input format I2S, LSB16/18/20, MSB
// (R06) DC cancel enable drives DC filter
// (R07) Volume attenuation 0..-60 dB, then infinite
// (R08) Bass boost per mode, capped 18/24
// (R09) Treble 0..6 dB unless flat
// (R10) Tone curve flat, min, min, max
// (R11) De-emphasis off, 32, 44.1, 48 kHz
// (R12) Mute flag mutes playback
// (R13) Power bits enable record, playback converters
// (R14) Address bits 1:0 pick transfer type
// (R15) Controller sends address with mode low
// (R16) Commit only after eighth bit
// (R17) Selection holds until next address byte
`default_nettype none
module acrd_top #(
  parameter logic [5:0] DEV_ADDR = acrd_pkg::DEV_ADDR_DEF
) (
  // Clock and reset
  input  wire logic       CORE_CLK,
  input  wire logic       RESET,
  // Control link pins
  input  wire logic       CTRL_MODE_LINE,
  input  wire logic       CTRL_CLOCK_LINE,
  input  wire logic       CTRL_DATA_LINE,
  // Decoded system settings
  output logic [1:0]      CLOCK_RATIO_SEL,
  output logic [2:0]      INPUT_FORMAT_SEL,
  output logic            DC_CANCEL_EN,
  output logic [5:0]      VOLUME_ATTEN_DB,
  output logic            VOLUME_INF,
  output logic [4:0]      BASS_BOOST_DB,
  output logic [2:0]      TREBLE_DB,
  output logic [1:0]      DEEMPH_SEL,
  output logic            MUTE_FLAG,
  output logic [1:0]      TONE_CURVE_SEL,
  output logic            REC_POWER_ON,
  output logic            PLAY_POWER_ON
);

  ////////////////////////////////////////////////////////////////////////
  typedef enum logic [1:0] {
    ACRD_CURVE_FLAT = 2'b00,
    ACRD_CURVE_MIN  = 2'b01,
    ACRD_CURVE_MAX  = 2'b10
  } acrd_curve_t;

  typedef struct packed {
    logic [1:0] mode_sync;
    logic [1:0] clk_sync;
    logic [1:0] data_sync;
    logic       clk_prev;
    logic       mode_prev;
    logic [7:0] shift;
    logic [2:0] bit_cnt;
    logic       selected;
    logic [1:0] xfer_type;
    logic [5:0] fmt_clk;
    logic [5:0] volume;
    logic [5:0] tone;
    logic [4:0] demph;
    logic [1:0] power;
    logic [1:0] clock_ratio_o;
    logic [2:0] input_format_o;
    logic       dc_o;
    logic [5:0] vol_db_o;
    logic       vol_inf_o;
    logic [4:0] bass_o;
    logic [2:0] treble_o;
    logic [1:0] deemph_o;
    logic       mute_o;
    logic [1:0] curve_o;
    logic       rec_o;
    logic       play_o;
  } acrd_state_t;

  acrd_state_t state_reg;
  acrd_state_t state_next;

  function automatic acrd_curve_t curve_of(input logic [1:0] sel);
    unique case (sel)
      2'b00:   curve_of = ACRD_CURVE_FLAT;
      2'b11:   curve_of = ACRD_CURVE_MAX;
      default: curve_of = ACRD_CURVE_MIN; // see (R10)
    endcase
  endfunction : curve_of

  ////////////////////////////////////////////////////////////////////////
  logic        clk_rise;
  logic        mode_s;
  logic [7:0]  byte_in;
  logic        byte_done;
  logic [1:0]  dsel;
  logic [1:0]  tsel;
  logic [3:0]  low_lvl;
  logic [4:0]  bass_raw;
  acrd_curve_t curve;

  always_comb begin
    state_next = state_reg;
    state_next.mode_sync = {state_reg.mode_sync[0], CTRL_MODE_LINE};
    state_next.clk_sync  = {state_reg.clk_sync[0], CTRL_CLOCK_LINE};
    state_next.data_sync = {state_reg.data_sync[0], CTRL_DATA_LINE};
    state_next.clk_prev  = state_reg.clk_sync[1];
    state_next.mode_prev = state_reg.mode_sync[1];
    mode_s    = state_reg.mode_sync[1];
    clk_rise  = state_reg.clk_sync[1] & ~state_reg.clk_prev;
    byte_in   = {state_reg.shift[6:0], state_reg.data_sync[1]};
    byte_done = clk_rise && (state_reg.bit_cnt == 3'h7);
    dsel      = byte_in[7:6];
    // Mode change discards a partial byte
    if (mode_s != state_reg.mode_prev) begin
      state_next.bit_cnt = 3'h0; // see (R16)
    end else if (clk_rise) begin
      state_next.shift   = byte_in;
      state_next.bit_cnt = state_reg.bit_cnt + 3'h1;
    end
    if (byte_done && mode_s == state_reg.mode_prev) begin
      if (!mode_s) begin
        // Address byte, see (R15)
        state_next.selected  = (byte_in[7:2] == DEV_ADDR); // see (R17)
        state_next.xfer_type = byte_in[1:0]; // see (R14)
      end else if (state_reg.selected) begin
        if (state_reg.xfer_type == acrd_pkg::TYPE_STATUS
            && !byte_in[7]) begin
          state_next.fmt_clk = byte_in[5:0]; // see (R01) see (R02)
        end else if (state_reg.xfer_type == acrd_pkg::TYPE_DATA) begin
          unique case (dsel) // see (R03)
            acrd_pkg::SEL_VOLUME: state_next.volume = byte_in[5:0];
            acrd_pkg::SEL_TONE:   state_next.tone   = byte_in[5:0];
            acrd_pkg::SEL_DEMPH:  state_next.demph  = byte_in[4:0];
            acrd_pkg::SEL_POWER:  state_next.power  = byte_in[1:0];
          endcase
        end
      end
    end
    // Decoded outputs, one cycle behind the stored fields
    state_next.clock_ratio_o  =
      state_reg.fmt_clk[acrd_pkg::ST_CLK_LSB +: 2]; // see (R04)
    state_next.input_format_o =
      state_reg.fmt_clk[acrd_pkg::ST_FMT_LSB +: 3]; // see (R05)
    state_next.dc_o = state_reg.fmt_clk[acrd_pkg::ST_DC_BIT]; // see (R06)
    // Codes 0 and 1 both give 0 dB
    state_next.vol_inf_o = (state_reg.volume >= acrd_pkg::VOL_MUTE_CODE);
    state_next.vol_db_o  = (state_reg.volume == 6'h00) ? 6'h00
                         : state_reg.volume - 6'h01; // see (R07)
    tsel     = state_reg.tone[1:0];
    low_lvl  = state_reg.tone[acrd_pkg::LOW_BOOST_LSB +: 4];
    bass_raw = {low_lvl, 1'b0};
    curve    = curve_of(state_reg.demph[1:0]);
    unique case (curve) // see (R08) see (R09)
      ACRD_CURVE_FLAT: begin
        state_next.bass_o   = 5'h00;
        state_next.treble_o = 3'h0;
      end
      ACRD_CURVE_MIN: begin
        state_next.bass_o   = (bass_raw > acrd_pkg::BASS_MIN_CAP)
                            ? acrd_pkg::BASS_MIN_CAP : bass_raw;
        state_next.treble_o = {tsel, 1'b0};
      end
      default: begin
        state_next.bass_o   = (bass_raw > acrd_pkg::BASS_MAX_CAP)
                            ? acrd_pkg::BASS_MAX_CAP : bass_raw;
        state_next.treble_o = {tsel, 1'b0};
      end
    endcase
    state_next.deemph_o =
      state_reg.demph[acrd_pkg::DEEMPH_LSB +: 2]; // see (R11)
    state_next.mute_o   = state_reg.demph[acrd_pkg::MUTE_BIT]; // see (R12)
    state_next.curve_o  = state_reg.demph[1:0]; // see (R10)
    state_next.rec_o    = state_reg.power[1]; // see (R13)
    state_next.play_o   = state_reg.power[0]; // see (R13)
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      state_reg           <= '0;
      // Link clock idles high; a low reset value would fake an edge
      state_reg.clk_sync  <= {2{acrd_pkg::LINK_IDLE}};
      state_reg.clk_prev  <= acrd_pkg::LINK_IDLE;
      state_reg.fmt_clk   <= acrd_pkg::FMT_CLK_RST;
      state_reg.volume    <= acrd_pkg::VOLUME_RST;
      state_reg.tone      <= acrd_pkg::TONE_RST;
      state_reg.demph     <= acrd_pkg::DEMPH_RST;
      state_reg.power     <= acrd_pkg::POWER_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  assign CLOCK_RATIO_SEL  = state_reg.clock_ratio_o;
  assign INPUT_FORMAT_SEL = state_reg.input_format_o;
  assign DC_CANCEL_EN     = state_reg.dc_o;
  assign VOLUME_ATTEN_DB  = state_reg.vol_db_o;
  assign VOLUME_INF       = state_reg.vol_inf_o;
  assign BASS_BOOST_DB    = state_reg.bass_o;
  assign TREBLE_DB        = state_reg.treble_o;
  assign DEEMPH_SEL       = state_reg.deemph_o;
  assign MUTE_FLAG        = state_reg.mute_o;
  assign TONE_CURVE_SEL   = state_reg.curve_o;
  assign REC_POWER_ON     = state_reg.rec_o;
  assign PLAY_POWER_ON    = state_reg.play_o;

  ////////////////////////////////////////////////////////////////////////
  logic commit_ok;
  assign commit_ok = byte_done && mode_s && state_reg.selected
                     && mode_s == state_reg.mode_prev;

  // One clock domain, so all checks share one clock and reset
  default clocking acrd_cb @(posedge CORE_CLK);
  endclocking
  default disable iff (RESET);

  sequence s_status_commit;
    commit_ok && state_reg.xfer_type == acrd_pkg::TYPE_STATUS && !byte_in[7];
  endsequence

  sequence s_status_drop;
    commit_ok && state_reg.xfer_type == acrd_pkg::TYPE_STATUS && byte_in[7];
  endsequence

  sequence s_vol_commit;
    commit_ok && state_reg.xfer_type == acrd_pkg::TYPE_DATA
      && byte_in[7:6] == acrd_pkg::SEL_VOLUME;
  endsequence

  sequence s_addr_byte;
    byte_done && !mode_s && mode_s == state_reg.mode_prev;
  endsequence

  // Field stored one edge after commit, decoded output one edge later
  chk_status_load: assert property ( // see (R01)
    s_status_commit |-> ##2 (CLOCK_RATIO_SEL == $past(byte_in[5:4], 2)
      && INPUT_FORMAT_SEL == $past(byte_in[3:1], 2)))
    else $error("status ratio not loaded");
  chk_dc_load: assert property ( // see (R02)
    s_status_commit |-> ##2 DC_CANCEL_EN == $past(byte_in[0], 2))
    else $error("dc enable not loaded");
  chk_status_ignore: assert property ( // see (R01)
    s_status_drop |=> $stable(state_reg.fmt_clk))
    else $error("status bit7 byte not ignored");
  chk_volume_map: assert property ( // see (R07)
    s_vol_commit |-> ##2
      VOLUME_INF == ($past(byte_in[5:0], 2) >= acrd_pkg::VOL_MUTE_CODE))
    else $error("volume infinite decode wrong");
  chk_partial_hold: assert property ( // see (R16)
    !byte_done |=> $stable(state_reg.volume))
    else $error("partial byte altered volume");
  chk_flat_zero: assert property ( // see (R08) see (R09)
    (state_reg.demph[1:0] == 2'h0)
      |=> (BASS_BOOST_DB == 5'h00 && TREBLE_DB == 3'h0))
    else $error("flat mode boost nonzero");
  chk_bass_cap: assert property ( // see (R08)
    (state_reg.demph[1:0] inside {2'h1, 2'h2})
      |=> BASS_BOOST_DB <= acrd_pkg::BASS_MIN_CAP)
    else $error("min bass over cap");
  chk_treble_map: assert property ( // see (R09)
    (state_reg.demph[1:0] != 2'h0)
      |=> TREBLE_DB == {$past(state_reg.tone[1:0]), 1'b0})
    else $error("treble decode wrong");
  chk_mute_map: assert property ( // see (R12)
    1'b1 |=> MUTE_FLAG == $past(state_reg.demph[acrd_pkg::MUTE_BIT]))
    else $error("mute decode wrong");
  chk_power_map: assert property ( // see (R13)
    1'b1 |=> (REC_POWER_ON == $past(state_reg.power[1])
      && PLAY_POWER_ON == $past(state_reg.power[0])))
    else $error("power decode wrong");
  chk_addr_type: assert property ( // see (R14)
    s_addr_byte |=> state_reg.xfer_type == $past(byte_in[1:0]))
    else $error("address type not taken");
  chk_dev_select: assert property ( // see (R17)
    s_addr_byte |=> state_reg.selected == ($past(byte_in[7:2]) == DEV_ADDR))
    else $error("device selection wrong");

endmodule : acrd_top
`default_nettype wire

// ==== verif/acrd_link_host.sv ====
// Purpose: Controller model driving the three-wire control link
// Assumes: Paced by the core clock, four core cycles per half bit
// Notes:   Link clock idles high and stands still between bytes
`default_nettype none
module acrd_link_host (
  // Pacing clock
  input  wire logic clk,
  // Link pins
  output var logic  mode_line,
  output var logic  clock_line,
  output var logic  data_line
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int HALF = 4;

  initial begin
    mode_line  = 1'b1;
    clock_line = 1'b1;
    data_line  = 1'b0;
  end

  task automatic wait_half();
    repeat (HALF) @(posedge clk);
    #1;
  endtask : wait_half

  // Mode moves only while the link clock is high
  task automatic send(input logic md, input logic [7:0] b, input int n);
    mode_line = md;
    wait_half();
    for (int i = 7; i > 7 - n; i--) begin
      clock_line = 1'b0;
      data_line  = b[i];
      wait_half();
      clock_line = 1'b1;
      wait_half();
    end
    // Released line shows the inverse so stale bits cannot pass
    data_line = ~data_line;
  endtask : send
endmodule : acrd_link_host
`default_nettype wire

// ==== verif/acrd_top_tb.sv ====
// Purpose: Self-checking bench for the control byte decoder
// Assumes: Outputs settle well within ten core cycles of a byte
// Notes:   Refused bytes are judged by unchanged outputs
`default_nettype none
module acrd_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [5:0] DEV = 6'h33; // Arbitrary device address
  logic       core_clk = 1'b0;
  logic       reset    = 1'b1;
  logic       mode, lclk, ldata, dc, inf, mute, rec, play;
  logic [1:0] ratio, deemph, curve;
  logic [2:0] fmt, treble;
  logic [4:0] bass;
  logic [5:0] atten;
  logic [5:0] vc [6] = '{6'h3f, 6'h3e, 6'h00, 6'h01, 6'h02, 6'h3d};
  logic [7:0] va [6] = '{8'd0, 8'd0, 8'd0, 8'd0, 8'd1, 8'd60};
  logic [7:0] stb [5] = '{8'h67, 8'h53, 8'h04, 8'h20, 8'h08};
  logic [7:0] bx [4] = '{8'd0, 8'd18, 8'd18, 8'd22};
  int         miscompares  = 0;
  int         total_checks = 0;
  int         cycles       = 0;

  always #20 core_clk = ~core_clk;

  acrd_top #(.DEV_ADDR(DEV)) DUT (
    .CORE_CLK(core_clk), .RESET(reset), .CTRL_MODE_LINE(mode),
    .CTRL_CLOCK_LINE(lclk), .CTRL_DATA_LINE(ldata),
    .CLOCK_RATIO_SEL(ratio), .INPUT_FORMAT_SEL(fmt), .DC_CANCEL_EN(dc),
    .VOLUME_ATTEN_DB(atten), .VOLUME_INF(inf), .BASS_BOOST_DB(bass),
    .TREBLE_DB(treble), .DEEMPH_SEL(deemph), .MUTE_FLAG(mute),
    .TONE_CURVE_SEL(curve), .REC_POWER_ON(rec), .PLAY_POWER_ON(play));

  acrd_link_host host (
    .clk(core_clk), .mode_line(mode), .clock_line(lclk),
    .data_line(ldata));

  ////////////////////////////////////////////////////////////////////
  task automatic chk(string name, logic [7:0] seen, logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic results();
    if (miscompares == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : results

  // Whole byte, then time for the commit to reach the outputs
  task automatic put(logic md, logic [7:0] b);
    host.send(md, b, 8);
    repeat (10) @(posedge core_clk);
    #1;
  endtask : put

  // Hang guard, about twice the expected run
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 6000) begin
      miscompares++;
      results();
    end
  end

  ////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge core_clk);
    #1;
    reset = 1'b0;
    put(1'b0, {DEV, 2'h2});
    foreach (stb[i]) begin
      put(1'b1, stb[i]);
      chk("ratio", ratio, {6'h0, stb[i][5:4]});
      chk("format", fmt, {5'h0, stb[i][3:1]});
      chk("dc", dc, {7'h0, stb[i][0]});
    end
    put(1'b1, 8'h98);
    chk("ratio", ratio, 8'h0);
    chk("format", fmt, 8'h4);
    chk("dc", dc, 8'h0);
    put(1'b0, {DEV, 2'h0});
    foreach (vc[i]) begin
      put(1'b1, {2'h0, vc[i]});
      chk("inf", inf, {7'h0, vc[i] > 6'h3d});
      if (vc[i] < 6'h3e)
        chk("atten", atten, va[i]);
    end
    put(1'b1, {2'h1, 4'hb, 2'h3});
    for (int m = 0; m < 4; m++) begin
      put(1'b1, {3'h4, m[1:0], m[0], m[1:0]});
      chk("deemph", deemph, {6'h0, m[1:0]});
      chk("mute", mute, {7'h0, m[0]});
      chk("curve", curve, {6'h0, m[1:0]});
      chk("bass", bass, bx[m]);
      chk("treble", treble, (m == 0) ? 8'd0 : 8'd6);
    end
    put(1'b1, 8'h7c);
    chk("bass", bass, 8'd24);
    chk("treble", treble, 8'd0);
    put(1'b1, {2'h1, 4'h4, 2'h1});
    put(1'b1, {3'h4, 2'h0, 1'b0, 2'h1});
    chk("bass", bass, 8'd8);
    chk("treble", treble, 8'd2);
    chk("deemph", deemph, 8'd0);
    chk("mute", mute, 8'd0);
    for (int p = 0; p < 4; p++) begin
      put(1'b1, {6'h30, p[1:0]});
      chk("rec", rec, {7'h0, p[1]});
      chk("play", play, {7'h0, p[0]});
    end
    // Half a byte, then a fresh address; stale bits must not merge
    host.send(1'b1, 8'h02, 4);
    put(1'b0, {DEV, 2'h0});
    put(1'b1, 8'h05);
    chk("atten", atten, 8'd4);
    put(1'b0, {DEV ^ 6'h01, 2'h0});
    put(1'b1, 8'h02);
    chk("atten", atten, 8'd4);
    put(1'b0, {DEV, 2'h1});
    put(1'b1, 8'h02);
    chk("atten", atten, 8'd4);
    put(1'b0, {DEV, 2'h0});
    put(1'b1, 8'h02);
    chk("atten", atten, 8'd1);
    results();
  end
endmodule : acrd_top_tb
`default_nettype wire
